// File: timer_event_irq_control.sv
`timescale 1ns/1ps
module timer_event_irq_control (
    // clock and reset
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst,
    // axi4-lite write address and data
    input  wire logic [timer_event_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                                 awvalid,
    output logic                                      awready,
    input  wire logic [31:0]                          wdata,
    input  wire logic [3:0]                           wstrb,
    input  wire logic                                 wvalid,
    output logic                                      wready,
    // axi4-lite write response
    output logic [1:0]                                bresp,
    output logic                                      bvalid,
    input  wire logic                                 bready,
    // axi4-lite read
    input  wire logic [timer_event_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                                 arvalid,
    output logic                                      arready,
    output logic [31:0]                               rdata,
    output logic [1:0]                                rresp,
    output logic                                      rvalid,
    input  wire logic                                 rready,
    // event routing
    input  wire logic                                 eventA,
    input  wire logic                                 eventB,
    // timer core
    input  wire timer_event_pkg::core_status_type     coreStatus,
    output timer_event_pkg::count_ctrl_type           countCtrl,
    output logic [15:0]                               periodBuffer,
    output logic [timer_event_pkg::NUM_CMP-1:0][15:0] compareBuffer,
    // interrupt
    output logic                                      irq
);
    localparam int unsigned NC = timer_event_pkg::NUM_CMP;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    function automatic timer_event_pkg::reg_sel_type decode(
        input logic [timer_event_pkg::ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = {2'h0, addr[timer_event_pkg::ADDR_W-1:2]};
        decode = timer_event_pkg::SEL_NONE;
        if (idx == timer_event_pkg::IDX_BUF_VALID) begin
            decode = timer_event_pkg::SEL_BUF_VALID;
        end else if (idx == timer_event_pkg::IDX_EVENT_CTL) begin
            decode = timer_event_pkg::SEL_EVENT_CTL;
        end else if (idx == timer_event_pkg::IDX_INT_EN) begin
            decode = timer_event_pkg::SEL_INT_EN;
        end else if (idx == timer_event_pkg::IDX_INT_FLAGS) begin
            decode = timer_event_pkg::SEL_INT_FLAGS;
        end else if (idx == timer_event_pkg::IDX_PER_BUF) begin
            decode = timer_event_pkg::SEL_PER_BUF;
        end else if (cmpIndex(addr) < NC) begin
            decode = timer_event_pkg::SEL_CMP_BUF;
        end
    endfunction

    // compare buffer number, NC when no compare buffer is addressed
    function automatic int unsigned cmpIndex(
        input logic [timer_event_pkg::ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = {2'h0, addr[timer_event_pkg::ADDR_W-1:2]};
        cmpIndex = NC;
        for (int unsigned n = 0; n < NC; n++) begin
            if (idx == timer_event_pkg::IDX_CMP_BUF0 + 8'(n) * timer_event_pkg::IDX_CMP_STEP) begin
                cmpIndex = n;
            end
        end
    endfunction

    logic [timer_event_pkg::ADDR_W-1:0] awAddr_reg;
    logic [31:0]                        wData_reg;
    logic [3:0]                         wStrb_reg;
    logic                               awHeld_reg;
    logic                               wHeld_reg;
    logic                               wrFire;
    timer_event_pkg::reg_sel_type       wrSel;
    timer_event_pkg::reg_sel_type       rdSel;
    logic [7:0]                         eventCtl_reg;
    logic [7:0]                         intEn_reg;
    logic [7:0]                         interrupt_flags_reg_reg;
    logic [NC:0]                        bufValid_reg;
    logic [NC:0]                        bufWrite;
    logic [7:0]                         flagSet;
    logic [7:0]                         flagClr;
    logic                               prevA_reg;
    logic                               prevB_reg;
    logic                               aEn;
    logic                               bEn;
    logic [2:0]                         aAct;
    logic [2:0]                         bAct;
    logic                               countNow;
    logic                               restartNow;
    logic                               dirEvent;
    logic                               dirLevel;

    // write channel: address and data taken in either order
    assign wrFire = awHeld_reg && wHeld_reg && !bvalid;
    assign wrSel  = decode(awAddr_reg);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            awready    <= 1'b1;
            awAddr_reg <= '0;
        end else if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awready    <= 1'b0;
            awAddr_reg <= awaddr;
        end else if (bvalid && bready) begin
            awHeld_reg <= 1'b0;
            awready    <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wHeld_reg <= 1'b0;
            wready    <= 1'b1;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wready    <= 1'b0;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
        end else if (bvalid && bready) begin
            wHeld_reg <= 1'b0;
            wready    <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= timer_event_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= (wrSel == timer_event_pkg::SEL_NONE) ?
                      timer_event_pkg::RESP_SLVERR : timer_event_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read channel: answer one cycle after the address is taken
    assign rdSel = decode(araddr);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= timer_event_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= timer_event_pkg::RESP_OKAY;
            rdata   <= '0;
            case (rdSel)
                timer_event_pkg::SEL_BUF_VALID: rdata[NC:0] <= bufValid_reg;
                timer_event_pkg::SEL_EVENT_CTL: rdata[7:0]  <= eventCtl_reg;
                timer_event_pkg::SEL_INT_EN:    rdata[7:0]  <= intEn_reg;
                timer_event_pkg::SEL_INT_FLAGS: rdata[7:0]  <= interrupt_flags_reg_reg;
                timer_event_pkg::SEL_PER_BUF:   rdata[15:0] <= periodBuffer;
                timer_event_pkg::SEL_CMP_BUF:   rdata[15:0] <= compareBuffer[cmpIndex(araddr)];
                default: rresp <= timer_event_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eventCtl_reg <= timer_event_pkg::REG8_RESET;
        end else if (wrFire && wStrb_reg[0] && wrSel == timer_event_pkg::SEL_EVENT_CTL) begin
            eventCtl_reg <= wData_reg[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            intEn_reg <= timer_event_pkg::REG8_RESET;
        end else if (wrFire && wStrb_reg[0] && wrSel == timer_event_pkg::SEL_INT_EN) begin
            intEn_reg <= wData_reg[7:0] & timer_event_pkg::INT_MASK;
        end
    end

    // sticky flags, a new event wins over a clearing write
    always_comb begin
        flagSet = '0;
        flagSet[timer_event_pkg::CMP_IRQ_LSB +: NC] = coreStatus.compareMatch;
        flagSet[timer_event_pkg::OVF_BIT] = coreStatus.topBottom;
        flagClr = '0;
        if (wrFire && wStrb_reg[0] && wrSel == timer_event_pkg::SEL_INT_FLAGS) begin
            flagClr = wData_reg[7:0] & timer_event_pkg::INT_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            interrupt_flags_reg_reg <= timer_event_pkg::REG8_RESET;
        end else begin
            interrupt_flags_reg_reg <= (interrupt_flags_reg_reg & ~flagClr) | flagSet;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(interrupt_flags_reg_reg & intEn_reg);
        end
    end

    property p_cmp_flag;
        coreStatus.compareMatch[0] |=> interrupt_flags_reg_reg[timer_event_pkg::CMP_IRQ_LSB] ##1
            (interrupt_flags_reg_reg[timer_event_pkg::CMP_IRQ_LSB] || $past(flagClr[timer_event_pkg::CMP_IRQ_LSB]));
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag lost");

    property p_ovf_sticky;
        interrupt_flags_reg_reg[timer_event_pkg::OVF_BIT] && !flagClr[timer_event_pkg::OVF_BIT] |=>
            interrupt_flags_reg_reg[timer_event_pkg::OVF_BIT];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");

    property p_irq_level;
        (|(interrupt_flags_reg_reg & intEn_reg)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");

    property p_irq_off;
        !(|(interrupt_flags_reg_reg & intEn_reg)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without source");

    // buffers and their valid bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            periodBuffer <= timer_event_pkg::PER_RESET;
        end else if (bufWrite[timer_event_pkg::PER_BV_BIT]) begin
            if (wStrb_reg[0]) periodBuffer[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) periodBuffer[15:8] <= wData_reg[15:8];
        end
    end

    assign bufWrite[timer_event_pkg::PER_BV_BIT] = wrFire && (|wStrb_reg[1:0]) &&
                                                    wrSel == timer_event_pkg::SEL_PER_BUF;

    for (genvar n = 0; n < NC; n++) begin : g_cmp
        assign bufWrite[timer_event_pkg::CMP_BV_LSB + n] = wrFire && (|wStrb_reg[1:0]) &&
            wrSel == timer_event_pkg::SEL_CMP_BUF && cmpIndex(awAddr_reg) == n;
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                compareBuffer[n] <= timer_event_pkg::CMP_RESET;
            end else if (bufWrite[timer_event_pkg::CMP_BV_LSB + n]) begin
                if (wStrb_reg[0]) compareBuffer[n][7:0] <= wData_reg[7:0];
                if (wStrb_reg[1]) compareBuffer[n][15:8] <= wData_reg[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bufValid_reg <= '0;
        end else begin
            bufValid_reg <= (bufValid_reg & ~{(NC+1){coreStatus.update}}) | bufWrite;
        end
    end

    property p_per_bv_set;
        bufWrite[timer_event_pkg::PER_BV_BIT] |=> bufValid_reg[timer_event_pkg::PER_BV_BIT];
    endproperty
    a_per_bv_set: assert property (p_per_bv_set) else $error("period valid not set");

    property p_cmp_bv_clr;
        coreStatus.update && !bufWrite[timer_event_pkg::CMP_BV_LSB] |=>
            !bufValid_reg[timer_event_pkg::CMP_BV_LSB];
    endproperty
    a_cmp_bv_clr: assert property (p_cmp_bv_clr) else $error("compare valid not cleared");

    // event inputs
    assign aEn  = eventCtl_reg[timer_event_pkg::EVA_EN_BIT];
    assign bEn  = eventCtl_reg[timer_event_pkg::EVB_EN_BIT];
    assign aAct = eventCtl_reg[timer_event_pkg::EVA_ACT_LSB +: 3];
    assign bAct = eventCtl_reg[timer_event_pkg::EVB_ACT_LSB +: 3];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prevA_reg <= 1'b0;
            prevB_reg <= 1'b0;
        end else begin
            prevA_reg <= eventA;
            prevB_reg <= eventB;
        end
    end

    always_comb begin
        countNow = coreStatus.prescaleTick;
        if (aEn) begin
            case (aAct)
                timer_event_pkg::A_COUNT_RISE: countNow = eventA && !prevA_reg;
                timer_event_pkg::A_COUNT_EDGE: countNow = eventA != prevA_reg;
                timer_event_pkg::A_COUNT_HIGH: countNow = coreStatus.prescaleTick && eventA;
                timer_event_pkg::A_EVENT_DIRECTION_COUNT:     countNow = coreStatus.prescaleTick;
                default:                       countNow = coreStatus.prescaleTick;
            endcase
        end
    end

    always_comb begin
        dirEvent = 1'b0;
        dirLevel = 1'b0;
        if (aEn && aAct == timer_event_pkg::A_EVENT_DIRECTION_COUNT) begin
            dirEvent = 1'b1;
            dirLevel = eventA;
        end else if (bEn && bAct == timer_event_pkg::B_EVENT_DIRECTION_COUNT) begin
            dirEvent = 1'b1;
            dirLevel = eventB;
        end
    end

    always_comb begin
        restartNow = 1'b0;
        if (bEn) begin
            case (bAct)
                timer_event_pkg::B_RESTART_RISE: restartNow = eventB && !prevB_reg;
                timer_event_pkg::B_RESTART_EDGE: restartNow = eventB != prevB_reg;
                timer_event_pkg::B_RESTART_HIGH: restartNow = eventB;
                default:                         restartNow = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            countCtrl <= '0;
        end else begin
            countCtrl.step         <= countNow;
            countCtrl.dirFromEvent <= dirEvent;
            countCtrl.restart      <= restartNow;
            if (countNow && dirEvent) begin
                countCtrl.down <= dirLevel;
            end
        end
    end

    property p_restart_rise;
        bEn && bAct == timer_event_pkg::B_RESTART_RISE && $rose(eventB) |=> countCtrl.restart;
    endproperty
    a_restart_rise: assert property (p_restart_rise) else $error("restart missed");

    property p_b_disabled;
        !bEn |=> !countCtrl.restart;
    endproperty
    a_b_disabled: assert property (p_b_disabled) else $error("restart while disabled");

    property p_reserved_b;
        !(bAct inside {timer_event_pkg::B_RESTART_RISE, timer_event_pkg::B_RESTART_EDGE,
                       timer_event_pkg::B_RESTART_HIGH}) |=> !countCtrl.restart;
    endproperty
    a_reserved_b: assert property (p_reserved_b) else $error("reserved code acted");

    property p_count_rise;
        aEn && aAct == timer_event_pkg::A_COUNT_RISE && $rose(eventA) |=> countCtrl.step;
    endproperty
    a_count_rise: assert property (p_count_rise) else $error("edge count missed");

    property p_event_direction_count_dir;
        aEn && aAct == timer_event_pkg::A_EVENT_DIRECTION_COUNT && coreStatus.prescaleTick |=>
            countCtrl.step && countCtrl.down == $past(eventA);
    endproperty
    a_event_direction_count_dir: assert property (p_event_direction_count_dir) else $error("direction not latched");
endmodule

// File: timer_event_pkg.sv
package timer_event_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned NUM_CMP      = 3;
    // register indices; byte address is index times four
    localparam logic [7:0]  IDX_BUF_VALID = 8'h06;
    localparam logic [7:0]  IDX_EVENT_CTL = 8'h09;
    localparam logic [7:0]  IDX_INT_EN    = 8'h0a;
    localparam logic [7:0]  IDX_INT_FLAGS = 8'h0b;
    localparam logic [7:0]  IDX_PER_BUF   = 8'h36;
    localparam logic [7:0]  IDX_CMP_BUF0  = 8'h38;
    localparam logic [7:0]  IDX_CMP_STEP  = 8'h02;
    // event control fields
    localparam int unsigned EVB_ACT_LSB  = 5;
    localparam int unsigned EVB_EN_BIT   = 4;
    localparam int unsigned EVA_ACT_LSB  = 1;
    localparam int unsigned EVA_EN_BIT   = 0;
    // interrupt fields
    localparam int unsigned CMP_IRQ_LSB  = 4;
    localparam int unsigned OVF_BIT      = 0;
    localparam logic [7:0]  INT_MASK     = 8'h71;
    // buffer valid fields
    localparam int unsigned PER_BV_BIT   = 0;
    localparam int unsigned CMP_BV_LSB   = 1;
    // reset values and response codes
    localparam logic [7:0]  REG8_RESET   = 8'h00;
    localparam logic [15:0] PER_RESET    = 16'hffff;
    localparam logic [15:0] CMP_RESET    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        B_NONE          = 3'h0,
        B_EVENT_DIRECTION_COUNT        = 3'h3,
        B_RESTART_RISE  = 3'h4,
        B_RESTART_EDGE  = 3'h5,
        B_RESTART_HIGH  = 3'h6
    } event_b_action_type;

    typedef enum logic [2:0] {
        A_COUNT_RISE    = 3'h0,
        A_COUNT_EDGE    = 3'h1,
        A_COUNT_HIGH    = 3'h2,
        A_EVENT_DIRECTION_COUNT        = 3'h3
    } event_a_action_type;

    typedef enum {
        SEL_NONE,
        SEL_BUF_VALID,
        SEL_EVENT_CTL,
        SEL_INT_EN,
        SEL_INT_FLAGS,
        SEL_PER_BUF,
        SEL_CMP_BUF
    } reg_sel_type;

    // inputs from the timer core, same clock
    typedef struct packed {
        logic                 update;
        logic [NUM_CMP-1:0]   compareMatch;
        logic                 topBottom;
        logic                 prescaleTick;
    } core_status_type;

    // count control towards the timer core
    typedef struct packed {
        logic step;
        logic down;
        logic dirFromEvent;
        logic restart;
    } count_ctrl_type;
endpackage

// File: event_core_model.sv
`timescale 1ns/1ps
module event_core_model (
    // clock
    input  wire logic                        ref_clk,
    // event lines and core status
    output logic                             eventA,
    output logic                             eventB,
    output timer_event_pkg::core_status_type coreStatus
);
    initial begin
        eventA = 1'b0;
        eventB = 1'b0;
        coreStatus = '0;
    end

    // levels lsb first, then lines back to idle low
    task automatic play(input logic [15:0] a, input logic [15:0] b, input logic tick, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk);
            eventA <= a[i];
            eventB <= b[i];
            coreStatus.prescaleTick <= tick;
        end
        @(posedge ref_clk);
        eventA <= 1'b0;
        eventB <= 1'b0;
        coreStatus.prescaleTick <= 1'b0;
    endtask

    task automatic pulse(input logic [2:0] m, input logic top, input logic upd);
        @(posedge ref_clk);
        coreStatus.compareMatch <= m;
        coreStatus.topBottom <= top;
        coreStatus.update <= upd;
        @(posedge ref_clk);
        coreStatus.compareMatch <= 3'h0;
        coreStatus.topBottom <= 1'b0;
        coreStatus.update <= 1'b0;
    endtask
endmodule

// File: timer_event_irq_control_tb.sv
`timescale 1ns/1ps
module timer_event_irq_control_tb;
    localparam logic [7:0] EVC = timer_event_pkg::IDX_EVENT_CTL;
    localparam logic [7:0] IEN = timer_event_pkg::IDX_INT_EN;
    localparam logic [7:0] IFL = timer_event_pkg::IDX_INT_FLAGS;
    localparam logic [7:0] BVL = timer_event_pkg::IDX_BUF_VALID;
    logic                             ref_clk = 1'b0;
    logic                             rst = 1'b1;
    logic [7:0]                       awaddr = 8'h0, araddr = 8'h0;
    logic [31:0]                      wdata = 32'h0, rdata, rd;
    logic [3:0]                       wstrb = 4'h0;
    logic                             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                             awready, wready, bvalid, arready, rvalid, eventA, eventB, irq;
    logic [1:0]                       bresp, rresp, resp;
    logic [15:0]                      periodBuffer;
    logic [2:0][15:0]                 compareBuffer;
    timer_event_pkg::core_status_type coreStatus;
    timer_event_pkg::count_ctrl_type  countCtrl;
    int                               fails = 0, checks = 0, stepCnt = 0, restartCnt = 0, i;

    always #5 ref_clk = ~ref_clk;

    timer_event_irq_control dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .eventA, .eventB, .coreStatus, .countCtrl, .periodBuffer, .compareBuffer, .irq);
    event_core_model model (.ref_clk, .eventA, .eventB, .coreStatus);

    always @(posedge ref_clk) begin
        if (countCtrl.step === 1'b1) stepCnt++;
        if (countCtrl.restart === 1'b1) restartCnt++;
    end

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int t;
        @(posedge ref_clk);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (t = 0; t < 40; t++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        chk("write wait", t < 40, 32'h1);
    endtask

    task automatic rdr(input logic [7:0] idx);
        int t;
        @(posedge ref_clk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (t = 0; t < 40; t++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        chk("read wait", t < 40, 32'h1);
    endtask

    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        rdr(idx);
        chk($sformatf("reg %h", idx), rd, exp);
        chk("rresp", resp, timer_event_pkg::RESP_OKAY);
    endtask

    // configure events, play levels, count step and restart pulses
    task automatic ev(input logic [7:0] ctl, input logic [15:0] a, input logic [15:0] b, input logic tick,
                      input int n, input int es, input int er, input int ed);
        int s0;
        int r0;
        wr(EVC, {24'h0, ctl});
        s0 = stepCnt;
        r0 = restartCnt;
        model.play(a, b, tick, n);
        repeat (3) @(posedge ref_clk);
        chk($sformatf("steps %h", ctl), stepCnt - s0, es);
        chk($sformatf("restarts %h", ctl), restartCnt - r0, er);
        if (ed >= 0) chk("down", countCtrl.down, ed);
        chk("event direction", countCtrl.dirFromEvent, ed >= 0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        results();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rc(EVC, 32'h0);
        rc(IEN, 32'h0);
        rc(IFL, 32'h0);
        rc(BVL, 32'h0);
        chk("period reset", periodBuffer, 32'hffff);
        wr(EVC, 32'ha5);
        chk("bresp", resp, timer_event_pkg::RESP_OKAY);
        rc(EVC, 32'ha5);
        wr(IEN, 32'hff);
        rc(IEN, 32'h71);
        wr(8'h01, 32'hff);
        chk("unmapped write", resp, timer_event_pkg::RESP_SLVERR);
        rdr(8'h01);
        chk("unmapped read", {rd[29:0], resp}, {30'h0, timer_event_pkg::RESP_SLVERR});
        wr(IEN, 32'h0);
        model.pulse(3'h7, 1'b1, 1'b0);
        repeat (4) @(posedge ref_clk);
        rc(IFL, 32'h71);
        chk("irq masked", irq, 32'h0);
        wr(IEN, 32'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq ovf", irq, 32'h1);
        wr(IFL, 32'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq ovf clear", irq, 32'h0);
        for (i = 0; i < 3; i++) begin
            wr(IEN, 32'h10 << i);
            repeat (2) @(posedge ref_clk);
            chk("irq cmp", irq, 32'h1);
            wr(IFL, 32'h10 << i);
            repeat (2) @(posedge ref_clk);
            chk("irq cmp clear", irq, 32'h0);
        end
        rc(IFL, 32'h0);
        wr(timer_event_pkg::IDX_PER_BUF, 32'h1234);
        rc(BVL, 32'h01);
        chk("period buffer", periodBuffer, 32'h1234);
        for (i = 0; i < 3; i++) begin
            wr(8'(timer_event_pkg::IDX_CMP_BUF0 + 2 * i), 32'ha0 + i);
            chk("compare buffer", compareBuffer[i], 32'ha0 + i);
            rc(BVL, (32'h1 << (i + 2)) - 1);
        end
        model.pulse(3'h0, 1'b0, 1'b1);
        repeat (2) @(posedge ref_clk);
        rc(BVL, 32'h0);
        ev(8'h01, 16'h36, 16'h0, 1'b0, 7, 2, 0, -1);
        ev(8'h03, 16'h36, 16'h0, 1'b0, 7, 4, 0, -1);
        ev(8'h05, 16'h0e, 16'h0, 1'b1, 7, 3, 0, -1);
        ev(8'h07, 16'h3f, 16'h0, 1'b1, 6, 6, 0, 1);
        ev(8'h07, 16'h00, 16'h0, 1'b1, 3, 3, 0, 0);
        ev(8'h00, 16'h36, 16'h0, 1'b1, 7, 7, 0, -1);
        ev(8'h09, 16'h36, 16'h0, 1'b1, 7, 7, 0, -1);
        ev(8'h90, 16'h0, 16'h36, 1'b0, 7, 0, 2, -1);
        ev(8'hb0, 16'h0, 16'h36, 1'b0, 7, 0, 4, -1);
        ev(8'hd0, 16'h0, 16'h0e, 1'b0, 7, 0, 3, -1);
        ev(8'h80, 16'h0, 16'h36, 1'b0, 7, 0, 0, -1);
        ev(8'h70, 16'h0, 16'h3f, 1'b1, 6, 6, 0, 1);
        for (i = 0; i < 8; i++) begin
            if (i inside {0, 1, 2, 7})
                ev(8'h10 | 8'(i << 5), 16'h0, 16'h36, 1'b0, 7, 0, 0, -1);
        end
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rc(EVC, 32'h0);
        rc(IEN, 32'h0);
        chk("period reset again", periodBuffer, 32'hffff);
        results();
    end
endmodule
